// File: tb/acfr_regs_top_asserts.sv
// Purpose: port assertions for the calibration register bank
// Assumes: one wait state per access, derived outputs lag registers by one clock
// Notes: bound to the top module
`timescale 1ns/100ps
`default_nettype none
module acfr_chk (
    input wire logic        CORE_CLK,
    input wire logic        RESET,
    input wire logic [7:0]  AVS_ADDRESS,
    input wire logic        AVS_READ,
    input wire logic        AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0]  AVS_BYTEENABLE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic        AVS_WAITREQUEST,
    input wire logic        GLOBAL_HIGHPASS_SETTING,
    input wire logic [23:0] CH1_GAIN,
    input wire logic [31:0] CH2_OFFSET,
    input wire logic [15:0] CH2_GAIN_HIGH_FIELD,
    input wire logic [9:0]  CH2_DELAY_FIELD,
    input wire logic        CH2_HIGHPASS_OFF,
    input wire logic        CH2_HIGHPASS_ACTIVE,
    input wire logic [1:0]  CH2_INPUT_SELECT,
    input wire logic [3:0]  CH2_INPUT_ONEHOT
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RESET);
    // full 16-bit write taking effect at this edge
    logic commit;
    logic rd_done;
    assign commit = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[1:0] == 2'h3;
    assign rd_done = AVS_READ && !AVS_WAITREQUEST;
    property p_rst_vals;
        $fell(RESET) |=> CH1_GAIN == 24'h800000 && CH2_OFFSET == 32'h0 && CH2_GAIN_HIGH_FIELD == 16'h8000
            && CH2_DELAY_FIELD == 10'h0 && CH2_INPUT_ONEHOT == 4'h1;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("reset output values wrong");
    property p_gain_hi;
        commit && AVS_ADDRESS == 8'h44 |-> ##2 CH1_GAIN[23:8] == $past(AVS_WRITEDATA[15:0], 2);
    endproperty
    a_gain_hi: assert property (p_gain_hi) else $error("gain high word not applied");
    property p_off_hi;
        commit && AVS_ADDRESS == 8'h50 |-> ##2 CH2_OFFSET[23:8] == $past(AVS_WRITEDATA[15:0], 2);
    endproperty
    a_off_hi: assert property (p_off_hi) else $error("offset high word not applied");
    property p_off_sign;
        CH2_OFFSET[31:24] == {8{CH2_OFFSET[23]}};
    endproperty
    a_off_sign: assert property (p_off_sign) else $error("offset not sign extended");
    property p_cfg;
        commit && AVS_ADDRESS == 8'h4c |-> ##2
            {CH2_DELAY_FIELD, 3'h0, CH2_HIGHPASS_OFF, CH2_INPUT_SELECT} == ($past(AVS_WRITEDATA[15:0], 2) & 16'hffc7);
    endproperty
    a_cfg: assert property (p_cfg) else $error("config fields not applied");
    property p_hp;
        !$past(RESET) |-> CH2_HIGHPASS_ACTIVE == ($past(GLOBAL_HIGHPASS_SETTING) & !CH2_HIGHPASS_OFF);
    endproperty
    a_hp: assert property (p_hp) else $error("high-pass enable wrong");
    property p_onehot;
        CH2_INPUT_ONEHOT == (4'h1 << CH2_INPUT_SELECT);
    endproperty
    a_onehot: assert property (p_onehot) else $error("input decode wrong");
    property p_rsvd_low;
        rd_done && (AVS_ADDRESS == 8'h40 || AVS_ADDRESS == 8'h48 || AVS_ADDRESS == 8'h54) |-> AVS_READDATA[7:0] == 8'h0;
    endproperty
    a_rsvd_low: assert property (p_rsvd_low) else $error("low byte not zero");
    property p_rsvd_cfg;
        rd_done && AVS_ADDRESS == 8'h4c |-> AVS_READDATA[5:3] == 3'h0;
    endproperty
    a_rsvd_cfg: assert property (p_rsvd_cfg) else $error("config spare bits not zero");
    // main scenarios
    c_cfg: cover property (commit && AVS_ADDRESS == 8'h4c);
    c_read: cover property (rd_done);
    c_hp: cover property (CH2_HIGHPASS_ACTIVE);
endmodule
bind acfr_regs_top acfr_chk i_acfr_chk (.CORE_CLK, .RESET, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
    .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .GLOBAL_HIGHPASS_SETTING, .CH1_GAIN, .CH2_OFFSET,
    .CH2_GAIN_HIGH_FIELD, .CH2_DELAY_FIELD, .CH2_HIGHPASS_OFF, .CH2_HIGHPASS_ACTIVE, .CH2_INPUT_SELECT,
    .CH2_INPUT_ONEHOT);
`default_nettype wire

// File: tb/acfr_tb.sv
// Purpose: self-checking bench for the calibration register bank
// Assumes: byte address is four times the index, waitrequest ends each access
// Notes: fixed-seed random traffic plus corner cases
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        CORE_CLK, RESET, AVS_READ, AVS_WRITE, GLOBAL_HIGHPASS_SETTING;
    logic [7:0]  AVS_ADDRESS, CH1_OFFSET_LOW_FIELD;
    logic [31:0] AVS_WRITEDATA, AVS_READDATA, CH2_OFFSET, q;
    logic [3:0]  AVS_BYTEENABLE, CH2_INPUT_ONEHOT;
    logic [23:0] CH1_GAIN;
    logic [15:0] CH2_GAIN_HIGH_FIELD;
    logic [9:0]  CH2_DELAY_FIELD;
    logic [1:0]  CH2_INPUT_SELECT;
    logic        AVS_WAITREQUEST, CH2_HIGHPASS_OFF, CH2_HIGHPASS_ACTIVE;
    logic [15:0] model [0:8];
    int          failures = 0, checks_done = 0, k;
    integer      seed = 32'hdef00913;
    acfr_regs_top i_acfr_regs_top (.CORE_CLK, .RESET, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
        .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .GLOBAL_HIGHPASS_SETTING, .CH1_OFFSET_LOW_FIELD,
        .CH1_GAIN, .CH2_OFFSET, .CH2_GAIN_HIGH_FIELD, .CH2_DELAY_FIELD, .CH2_HIGHPASS_OFF,
        .CH2_HIGHPASS_ACTIVE, .CH2_INPUT_SELECT, .CH2_INPUT_ONEHOT);
    // writable bits per index; 7 and 8 are unmapped words
    function automatic logic [15:0] wmask(int i);
        return (i == 0 || i == 2 || i == 5) ? 16'hff00 : (i == 3) ? 16'hffc7 : (i > 6) ? 16'h0 : 16'hffff;
    endfunction
    function automatic logic [7:0] addr_of(int i);
        return (i == 8) ? 8'h3c : 8'h40 + 8'(4 * i);
    endfunction
    task automatic model_reset;
        for (int i = 0; i < 9; i++) model[i] = (i == 1 || i == 6) ? 16'h8000 : 16'h0;
    endtask
    // one transfer, held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input int i, input logic [15:0] d, input logic [1:0] be);
        logic        w;
        logic [15:0] b;
        b = {{8{be[1]}}, {8{be[0]}}} & wmask(i);
        @(posedge CORE_CLK);
        AVS_ADDRESS <= addr_of(i);
        AVS_WRITEDATA <= {16'h0, d};
        AVS_BYTEENABLE <= {2'h0, be};
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        // waitrequest and read data are taken at the rising edge, before that edge updates them;
        // only the watchdog ends a wait that never completes
        do begin
            @(posedge CORE_CLK);
            w = AVS_WAITREQUEST;
            q = AVS_READDATA;
        end while (w !== 1'b0);
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
        if (wr) model[i] = (model[i] & ~b) | (d & b);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rd(input int i);
        bus(1'b0, i, 16'h0, 2'h3);
        chk("readback", {16'h0, model[i]}, q);
    endtask
    // let derived outputs catch up with the registers
    task automatic settle;
        repeat (3) @(posedge CORE_CLK);
        @(negedge CORE_CLK);
    endtask
    task automatic wrap_up;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        CORE_CLK = 1'b0;
        forever #5 CORE_CLK = ~CORE_CLK;
    end
    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge CORE_CLK);
        failures++;
        wrap_up();
    end
    initial begin
        RESET = 1'b1;
        AVS_READ = 1'b0;
        AVS_WRITE = 1'b0;
        AVS_ADDRESS = 8'h0;
        AVS_WRITEDATA = 32'h0;
        AVS_BYTEENABLE = 4'h0;
        GLOBAL_HIGHPASS_SETTING = 1'b0;
        model_reset();
        repeat (8) @(posedge CORE_CLK);
        RESET <= 1'b0;
        settle();
        chk("gain1", 32'h800000, CH1_GAIN);
        chk("gain2_hi", 32'h8000, CH2_GAIN_HIGH_FIELD);
        chk("onehot", 32'h1, CH2_INPUT_ONEHOT);
        for (k = 0; k < 9; k++) rd(k);
        for (k = 0; k < 9; k++) bus(1'b1, k, 16'hffff, 2'h3);
        for (k = 0; k < 9; k++) rd(k);
        repeat (60) begin
            bus(1'b1, $unsigned($random(seed)) % 9, 16'($random(seed)), 2'($random(seed)));
            rd($unsigned($random(seed)) % 9);
        end
        for (k = 0; k < 8; k++) begin
            GLOBAL_HIGHPASS_SETTING <= k[1];
            bus(1'b1, 3, {10'h200, 3'h7, k[0], k[2:1]}, 2'h3);
            settle();
            chk("sel", {30'h0, k[2:1]}, CH2_INPUT_SELECT);
            chk("onehot", 32'h1 << k[2:1], CH2_INPUT_ONEHOT);
            chk("delay", 32'h200, CH2_DELAY_FIELD);
            chk("hp_off", k[0], CH2_HIGHPASS_OFF);
            chk("hp_on", k[1] & ~k[0], CH2_HIGHPASS_ACTIVE);
            rd(3);
        end
        bus(1'b1, 4, 16'h8001, 2'h3);
        bus(1'b1, 5, 16'hab00, 2'h3);
        bus(1'b1, 0, 16'h5a00, 2'h3);
        bus(1'b1, 1, 16'hffff, 2'h3);
        bus(1'b1, 2, 16'hff00, 2'h3);
        bus(1'b1, 6, 16'h1234, 2'h3);
        settle();
        chk("offset2", 32'hff8001ab, CH2_OFFSET);
        chk("offset1", 32'h5a, CH1_OFFSET_LOW_FIELD);
        chk("gain1", 32'hffffff, CH1_GAIN);
        chk("gain2_hi", 32'h1234, CH2_GAIN_HIGH_FIELD);
        bus(1'b1, 4, 16'h7fff, 2'h3);
        settle();
        chk("offset2", 32'h007fffab, CH2_OFFSET);
        @(posedge CORE_CLK);
        RESET <= 1'b1;
        repeat (2) @(posedge CORE_CLK);
        RESET <= 1'b0;
        model_reset();
        for (k = 0; k < 7; k++) rd(k);
        settle();
        chk("gain1", 32'h800000, CH1_GAIN);
        chk("gain2_hi", 32'h8000, CH2_GAIN_HIGH_FIELD);
        chk("offset2", 32'h0, CH2_OFFSET);
        chk("offset1", 32'h0, CH1_OFFSET_LOW_FIELD);
        chk("delay", 32'h0, CH2_DELAY_FIELD);
        chk("onehot", 32'h1, CH2_INPUT_ONEHOT);
        wrap_up();
    end
endmodule
`default_nettype wire

// File: verilog/acfr_cal_join.v
// Purpose : joins a high word and a low byte into a registered 24-bit calibration value
// Assumes : low byte sits in bits 15:8 of its register
// Notes   : signed values are sign-extended to 32 bits; output lags the registers by one cycle
`timescale 1ns/100ps
`default_nettype none
module acfr_cal_join #(
    parameter IS_SIGNED = 0
) (
    input  wire        clk,
    input  wire        rst,
    input  wire [15:0] high_word,
    input  wire [15:0] low_reg,
    input  wire [23:0] reset_val,
    output wire [31:0] value
);
    reg  [31:0] value_r;
    wire [23:0] joined;
    wire [7:0]  ext;

    // bits 23:8 from the high word, bits 7:0 from the low register upper byte
    assign joined = {high_word, low_reg[15:8]};
    assign ext    = (IS_SIGNED != 0) ? {8{joined[23]}} : 8'h00;

    // registered output of the assembled value, reset to the register bank's own reset value
    always @(posedge clk) begin
        if (rst) begin
            value_r <= {((IS_SIGNED != 0) ? {8{reset_val[23]}} : 8'h00), reset_val};
        end else begin
            value_r <= {ext, joined};
        end
    end

    assign value = value_r;
endmodule
`default_nettype wire

// File: verilog/acfr_defines.vh
// Purpose : constants for the channel calibration and configuration register bank
// Assumes : 16-bit registers, one per aligned 32-bit Avalon word, byte address = 4 * index
// Notes   : indices are the printed register offsets; the byte address is four times the index
//
// Function
// - offset high word holds offset bits 23 to 8 in all sixteen bits, read/write.
// - offset low register holds offset bits 7 to 0 in bits 15 to 8.
// - assembled 24-bit offset is a signed two's complement number.
// - assembled 24-bit gain is unsigned, zero to just below two; high word gives bits 23:8.
// - gain low register holds gain bits 7 to 0 in bits 15 to 8.
// - gain high words reset to 8000h; gain low and offset registers reset to 0000h.
// - lower byte of each offset and gain low register always reads zero.
// - configuration bits 15 to 6 hold a signed 10-bit phase delay in modulator cycles.
// - configuration bit 2 set disables high-pass for this channel; clear follows global.
// - configuration bits 1:0 pick own pins, shorted, positive test, negative test.
// - configuration bits 5 to 3 are reserved and always read zero.
// - channel 2 configuration sits at index 13h and resets to 0000h.
`ifndef ACFR_DEFINES_VH
`define ACFR_DEFINES_VH

// register indices
`define ACFR_IDX_FIRST            6'h10
`define ACFR_IDX_LAST             6'h16
`define ACFR_NUM_REGS             7
`define ACFR_IDX_CH1_OFFSET_LOW   6'h10
`define ACFR_IDX_CH1_GAIN_HIGH    6'h11
`define ACFR_IDX_CH1_GAIN_LOW     6'h12
`define ACFR_IDX_CH2_CONFIG       6'h13
`define ACFR_IDX_CH2_OFFSET_HIGH  6'h14
`define ACFR_IDX_CH2_OFFSET_LOW   6'h15
`define ACFR_IDX_CH2_GAIN_HIGH    6'h16

// reset values
`define ACFR_RST_GAIN_HIGH        16'h8000
`define ACFR_RST_ZERO             16'h0000

// writable bit masks
`define ACFR_MASK_FULL            16'hffff
`define ACFR_MASK_LOW_BYTE_REG    16'hff00
`define ACFR_MASK_CONFIG          16'hffc7

// configuration field positions
`define ACFR_CFG_DELAY_HI         15
`define ACFR_CFG_DELAY_LO         6
`define ACFR_CFG_HIGHPASS_OFF     2
`define ACFR_CFG_SEL_HI           1
`define ACFR_CFG_SEL_LO           0

// input selector codes
`define ACFR_SEL_PINS             2'h0
`define ACFR_SEL_SHORTED          2'h1
`define ACFR_SEL_TEST_POS         2'h2
`define ACFR_SEL_TEST_NEG         2'h3

`endif

// File: verilog/acfr_reg16.v
// Purpose : one 16-bit software register with a writable-bit mask
// Assumes : synchronous active-high reset, byte-lane write strobes expanded to bits
// Notes   : bits outside the mask are constant zero and ignore writes
`timescale 1ns/100ps
`default_nettype none
module acfr_reg16 #(
    parameter [15:0] RESET_VAL = 16'h0000,
    parameter [15:0] WR_MASK   = 16'hffff
) (
    input  wire        clk,
    input  wire        rst,
    input  wire        wr_en,
    input  wire [15:0] wr_data,
    input  wire [15:0] wr_bits,
    output wire [15:0] q
);
    reg  [15:0] q_r;
    wire [15:0] keep_m;

    // only bits both strobed and writable take new data
    assign keep_m = wr_bits & WR_MASK;

    // register update, reserved bits forced to zero
    always @(posedge clk) begin
        if (rst) begin
            q_r <= RESET_VAL & WR_MASK;
        end else if (wr_en) begin
            q_r <= ((q_r & ~keep_m) | (wr_data & keep_m)) & WR_MASK;
        end
    end

    assign q = q_r;
endmodule
`default_nettype wire

// File: verilog/acfr_regs_top.v
// Purpose : channel calibration and configuration register bank behind an Avalon-MM slave
// Assumes : 32-bit Avalon data, byte addresses, one wait state on every access
// Notes   : unmapped words read zero and ignore writes; data bits 31:16 read zero
`timescale 1ns/100ps
`include "acfr_defines.vh"
`default_nettype none
module acfr_regs_top (
    input  wire        CORE_CLK,
    input  wire        RESET,
    input  wire [7:0]  AVS_ADDRESS,
    input  wire        AVS_READ,
    input  wire        AVS_WRITE,
    input  wire [31:0] AVS_WRITEDATA,
    input  wire [3:0]  AVS_BYTEENABLE,
    output wire [31:0] AVS_READDATA,
    output wire        AVS_WAITREQUEST,
    input  wire        GLOBAL_HIGHPASS_SETTING,
    output wire [7:0]  CH1_OFFSET_LOW_FIELD,
    output wire [23:0] CH1_GAIN,
    output wire [31:0] CH2_OFFSET,
    output wire [15:0] CH2_GAIN_HIGH_FIELD,
    output wire [9:0]  CH2_DELAY_FIELD,
    output wire        CH2_HIGHPASS_OFF,
    output wire        CH2_HIGHPASS_ACTIVE,
    output wire [1:0]  CH2_INPUT_SELECT,
    output wire [3:0]  CH2_INPUT_ONEHOT
);
    localparam NREG = `ACFR_NUM_REGS;

    // reset values, register 0 in the low slice
    localparam [NREG*16-1:0] RST_ALL = {
        `ACFR_RST_GAIN_HIGH,     // ch2 gain high
        `ACFR_RST_ZERO,          // ch2 offset low
        `ACFR_RST_ZERO,          // ch2 offset high
        `ACFR_RST_ZERO,          // ch2 config
        `ACFR_RST_ZERO,          // ch1 gain low
        `ACFR_RST_GAIN_HIGH,     // ch1 gain high
        `ACFR_RST_ZERO           // ch1 offset low
    };

    // writable masks, reserved bits excluded
    localparam [NREG*16-1:0] MASK_ALL = {
        `ACFR_MASK_FULL,
        `ACFR_MASK_LOW_BYTE_REG,
        `ACFR_MASK_FULL,
        `ACFR_MASK_CONFIG,
        `ACFR_MASK_LOW_BYTE_REG,
        `ACFR_MASK_FULL,
        `ACFR_MASK_LOW_BYTE_REG
    };

    // address decode: one-hot select of the addressed register, zero when unmapped
    function [NREG-1:0] reg_select;
        input [7:0] addr;
        reg   [5:0] idx;
        reg   [5:0] rel;
        begin
            idx        = addr[7:2];
            rel        = idx - `ACFR_IDX_FIRST;
            reg_select = {NREG{1'b0}};
            if ((idx >= `ACFR_IDX_FIRST) && (idx <= `ACFR_IDX_LAST)) begin
                reg_select[rel[2:0]] = 1'b1;
            end
        end
    endfunction

    // selector decode into one line per input source
    function [3:0] input_decode;
        input [1:0] sel;
        begin
            case (sel)
                `ACFR_SEL_PINS:     input_decode = 4'h1;
                `ACFR_SEL_SHORTED:  input_decode = 4'h2;
                `ACFR_SEL_TEST_POS: input_decode = 4'h4;
                `ACFR_SEL_TEST_NEG: input_decode = 4'h8;
                default:            input_decode = 4'h1;
            endcase
        end
    endfunction

    reg                 ack_r;
    wire                ack_nxt;
    reg  [31:0]         rdata_r;
    reg  [31:0]         rdata_nxt;
    wire                req;
    wire                commit;
    wire [NREG-1:0]     sel_now;
    wire [15:0]         wr_bits;
    wire [NREG*16-1:0]  reg_q_all;
    wire [15:0]         q_ch1_off_lo;
    wire [15:0]         q_ch1_gain_hi;
    wire [15:0]         q_ch1_gain_lo;
    wire [15:0]         q_ch2_config;
    wire [15:0]         q_ch2_off_hi;
    wire [15:0]         q_ch2_off_lo;
    wire [15:0]         q_ch2_gain_hi;
    wire [31:0]         ch1_gain_w;
    integer             k;

    // one wait state: ack rises the cycle after a request and drops after the handshake
    assign req             = AVS_READ | AVS_WRITE;
    assign ack_nxt         = req & ~ack_r;
    assign AVS_WAITREQUEST = req & ~ack_r;
    assign commit          = AVS_WRITE & ack_r;
    assign sel_now         = reg_select(AVS_ADDRESS);

    // byte enables 0 and 1 cover the 16 data bits
    assign wr_bits = {{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

    // handshake state
    always @(posedge CORE_CLK) begin
        if (RESET) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= ack_nxt;
        end
    end

    // register array, each with its own reset value and writable mask
    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi = gi + 1) begin : g_reg
            acfr_reg16 #(
                .RESET_VAL (RST_ALL[gi*16 +: 16]),
                .WR_MASK   (MASK_ALL[gi*16 +: 16])
            ) u_reg (
                .clk     (CORE_CLK),
                .rst     (RESET),
                .wr_en   (commit & sel_now[gi]),
                .wr_data (AVS_WRITEDATA[15:0]),
                .wr_bits (wr_bits),
                .q       (reg_q_all[gi*16 +: 16])
            );
        end
    endgenerate

    // named views of the array
    assign q_ch1_off_lo  = reg_q_all[0*16 +: 16];
    assign q_ch1_gain_hi = reg_q_all[1*16 +: 16];
    assign q_ch1_gain_lo = reg_q_all[2*16 +: 16];
    assign q_ch2_config     = reg_q_all[3*16 +: 16];
    assign q_ch2_off_hi  = reg_q_all[4*16 +: 16];
    assign q_ch2_off_lo  = reg_q_all[5*16 +: 16];
    assign q_ch2_gain_hi = reg_q_all[6*16 +: 16];

    // read mux; reserved bits are already zero in storage, upper half is zero
    always @* begin
        rdata_nxt = 32'h00000000;
        for (k = 0; k < NREG; k = k + 1) begin
            if (sel_now[k]) begin
                rdata_nxt = {16'h0000, reg_q_all[k*16 +: 16]};
            end
        end
    end

    // read data captured as ack rises, held through the handshake edge
    always @(posedge CORE_CLK) begin
        if (RESET) begin
            rdata_r <= 32'h00000000;
        end else if (AVS_READ & ~ack_r) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign AVS_READDATA = rdata_r;

    // ch1 gain: unsigned 24-bit from high word and low register
    acfr_cal_join #(
        .IS_SIGNED (0)
    ) u_ch1_gain (
        .clk       (CORE_CLK),
        .rst       (RESET),
        .high_word (q_ch1_gain_hi),
        .low_reg   (q_ch1_gain_lo),
        .reset_val ({`ACFR_RST_GAIN_HIGH, 8'h00}),
        .value     (ch1_gain_w)
    );

    assign CH1_GAIN = ch1_gain_w[23:0];

    // ch2 offset: signed 24-bit, sign-extended
    acfr_cal_join #(
        .IS_SIGNED (1)
    ) u_ch2_offset (
        .clk       (CORE_CLK),
        .rst       (RESET),
        .high_word (q_ch2_off_hi),
        .low_reg   (q_ch2_off_lo),
        .reset_val ({`ACFR_RST_ZERO, 8'h00}),
        .value     (CH2_OFFSET)
    );

    // ch2 configuration fields, derived controls, ch1 offset low and ch2 gain high fields, registered
    reg [9:0] delay_r;
    reg       hp_off_r;
    reg       hp_active_r;
    reg [1:0] sel_r;
    reg [3:0] onehot_r;
    reg [7:0] ch1_off_lo_r;
    reg [15:0] ch2_gain_hi_r;

    always @(posedge CORE_CLK) begin
        if (RESET) begin
            delay_r       <= 10'h000;
            hp_off_r      <= 1'b0;
            hp_active_r   <= 1'b0;
            sel_r         <= 2'h0;
            onehot_r      <= 4'h1;
            ch1_off_lo_r  <= 8'h00;
            ch2_gain_hi_r <= `ACFR_RST_GAIN_HIGH;
        end else begin
            delay_r       <= q_ch2_config[`ACFR_CFG_DELAY_HI:`ACFR_CFG_DELAY_LO];
            hp_off_r      <= q_ch2_config[`ACFR_CFG_HIGHPASS_OFF];
            hp_active_r   <= GLOBAL_HIGHPASS_SETTING & ~q_ch2_config[`ACFR_CFG_HIGHPASS_OFF];
            sel_r         <= q_ch2_config[`ACFR_CFG_SEL_HI:`ACFR_CFG_SEL_LO];
            onehot_r      <= input_decode(q_ch2_config[`ACFR_CFG_SEL_HI:`ACFR_CFG_SEL_LO]);
            ch1_off_lo_r  <= q_ch1_off_lo[15:8];
            ch2_gain_hi_r <= q_ch2_gain_hi;
        end
    end

    // reserved config bits 5:3 are outside the writable mask and never reach a field
    assign CH2_DELAY_FIELD      = delay_r;
    assign CH2_HIGHPASS_OFF     = hp_off_r;
    assign CH2_HIGHPASS_ACTIVE  = hp_active_r;
    assign CH2_INPUT_SELECT     = sel_r;
    assign CH2_INPUT_ONEHOT     = onehot_r;
    assign CH1_OFFSET_LOW_FIELD = ch1_off_lo_r;
    assign CH2_GAIN_HIGH_FIELD  = ch2_gain_hi_r;
endmodule
`default_nettype wire
